/* ldc_pkg.sv */
// Shared constants, types and decoders for the loop detector channel configuration block
package ldc_pkg;
	localparam int CH_N = 4;
	localparam int L_W = 22;
	localparam int THR_W = 11;
	localparam int THR_MAX_NH = 1024;
	localparam int SEL_W = 4;
	localparam int IDX_W = 3;
	localparam int DLY_W = 5;
	localparam int EXT_W = 5;
	localparam int QCNT_W = 7;
	localparam int QTR_PER_SEC = 4;
	localparam logic [3:0] SEL_OFF = 4'h0;
	localparam logic [7:0] ADDR_MIN = 8'h80;
	localparam logic [7:0] ADDR_MAX = 8'hfe;
	localparam logic [7:0] ADDR_WILD = 8'hff;
	localparam logic [7:0] ADDR_BP_BASE = 8'h80;
	localparam logic [7:0] ADDR_RST = 8'h80;
	localparam logic [5:0] MD_BASIC = 6'h08;
	localparam logic [5:0] MD_EXP = 6'h20;
	localparam logic [1:0] FREQ_ILLEGAL = 2'h3;
	localparam logic [1:0] FREQ_RST = 2'h0;
	// Debounced pin vector layout
	localparam int DB_SEL = 0;
	localparam int DB_FREQ = 16;
	localparam int DB_BP = 18;
	localparam int DB_PHASE = 22;
	localparam int DB_COMM = 23;
	localparam int DB_W = 24;
	// Times in their own units, cycle counts derived from the 250 MHz clock
	localparam longint CLK_HZ = 250000000;
	localparam longint QTICK_MS = 250;
	localparam longint DEB_MS = 10;
	localparam longint TUNE_MS = 4000;
	localparam longint PULSE_MS = 188;
	localparam int QTICK_CYC = int'(CLK_HZ * QTICK_MS / 1000);
	localparam int DEB_CYC = int'(CLK_HZ * DEB_MS / 1000);
	localparam int TUNE_CYC = int'(CLK_HZ * TUNE_MS / 1000);
	localparam int PULSE_CYC = int'(CLK_HZ * PULSE_MS / 1000);
	localparam longint BAUD_OVS = 16;
	typedef enum logic [2:0] {
		BAUD_1200 = 3'h0,
		BAUD_2400 = 3'h1,
		BAUD_4800 = 3'h2,
		BAUD_9600 = 3'h3,
		BAUD_19200 = 3'h4
	} ldc_baud_type;
	localparam logic [15:0] BAUD_DIV_RST = 16'(CLK_HZ / (BAUD_OVS * 9600));
	typedef enum logic [2:0] {
		T_IDLE = 3'h0,
		T_DELAY = 3'h1,
		T_ON = 3'h2,
		T_EXT = 3'h3,
		T_PULSE = 3'h4,
		T_HOLD = 3'h5
	} ldc_tstate_type;
	// Divisor for sixteen samples per bit; an unlisted code falls back to 9600
	function automatic logic [15:0] baud_div(input logic [2:0] code);
		case (code)
			BAUD_1200: baud_div = 16'(CLK_HZ / (BAUD_OVS * 1200));
			BAUD_2400: baud_div = 16'(CLK_HZ / (BAUD_OVS * 2400));
			BAUD_4800: baud_div = 16'(CLK_HZ / (BAUD_OVS * 4800));
			BAUD_19200: baud_div = 16'(CLK_HZ / (BAUD_OVS * 19200));
			default: baud_div = BAUD_DIV_RST;
		endcase
	endfunction
	// Threshold in nH: index 0 is least sensitive, each step halves
	function automatic logic [THR_W-1:0] thr_nh(input logic [IDX_W-1:0] idx);
		thr_nh = THR_W'(THR_MAX_NH >> idx);
	endfunction
endpackage

/* ldc_tmr_if.sv */
// Per-channel link between the configuration core and its output timer
`timescale 1ns/1ns
interface ldc_tmr_if;
	logic detect;
	logic pulse_mode;
	logic allow_delay;
	logic allow_ext;
	logic qtick;
	logic [6:0] delay_q;
	logic [4:0] ext_q;
	logic out;
	modport ctl (output detect, pulse_mode, allow_delay, allow_ext, qtick, delay_q, ext_q,
		input out);
	modport tmr (input detect, pulse_mode, allow_delay, allow_ext, qtick, delay_q, ext_q,
		output out);
endinterface

/* ldc_debounce.sv */
// Two-stage synchroniser and stability filter for switch and pin inputs
`timescale 1ns/1ns
module ldc_debounce #(
	parameter int W = 24,
	parameter int STABLE_CYC = 2500000
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] last;
		logic [31:0] cnt;
		logic [W-1:0] dout;
	} ldc_db_state_type;
	ldc_db_state_type st;
	ldc_db_state_type next_st;

	// A change restarts the count; the value is taken only after it held still
	always_comb begin
		next_st = st;
		next_st.s1 = din;
		next_st.s2 = st.s1;
		next_st.last = st.s2;
		if (st.s2 != st.last) begin
			next_st.cnt = 32'h0;
		end else if (st.cnt != 32'(STABLE_CYC - 1)) begin
			next_st.cnt = st.cnt + 32'h1;
		end else begin
			next_st.dout = st.s2; // R22
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign dout = st.dout;

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	stable_take_a: assert property ($changed(st.dout) |-> $past(st.cnt) == 32'(STABLE_CYC - 1)) // R22
		else $error("debounced value changed before the input was stable");
endmodule

/* ldc_timer.sv */
// Per-channel delay, extension and pulse output timer
`timescale 1ns/1ns
module ldc_timer #(
	parameter int PULSE_CYC = ldc_pkg::PULSE_CYC
) (
	input wire logic mclk,
	input wire logic nrst,
	ldc_tmr_if.tmr tif
);
	typedef struct packed {
		ldc_pkg::ldc_tstate_type state;
		logic [ldc_pkg::QCNT_W-1:0] qcnt;
		logic [31:0] pcnt;
		logic out;
	} ldc_tmr_state_type;
	ldc_tmr_state_type st;
	ldc_tmr_state_type next_st;

	// Quarter ticks are free running, so the first step of a count may be short
	always_comb begin
		next_st = st;
		unique case (st.state)
			ldc_pkg::T_IDLE: begin
				next_st.qcnt = '0;
				next_st.pcnt = 32'h0;
				if (tif.detect) begin
					if (tif.pulse_mode) begin
						next_st.state = ldc_pkg::T_PULSE; // R13
					end else if (!tif.allow_delay || tif.delay_q == 7'h0) begin
						next_st.state = ldc_pkg::T_ON; // R11
					end else begin
						next_st.state = ldc_pkg::T_DELAY; // R19
					end
				end
			end
			ldc_pkg::T_DELAY: begin
				if (!tif.detect) begin
					next_st.state = ldc_pkg::T_IDLE;
				end else if (!tif.allow_delay) begin
					next_st.state = ldc_pkg::T_ON; // R11
				end else if (tif.qtick) begin
					next_st.qcnt = st.qcnt + 7'h1;
					if (st.qcnt + 7'h1 >= tif.delay_q) begin
						next_st.state = ldc_pkg::T_ON; // R19
					end
				end
			end
			ldc_pkg::T_ON: begin
				next_st.qcnt = '0;
				if (!tif.detect) begin
					if (tif.allow_ext && tif.ext_q != 5'h0) begin
						next_st.state = ldc_pkg::T_EXT; // R11
					end else begin
						next_st.state = ldc_pkg::T_IDLE;
					end
				end
			end
			ldc_pkg::T_EXT: begin
				if (tif.detect) begin
					next_st.state = ldc_pkg::T_ON;
				end else if (!tif.allow_ext) begin
					next_st.state = ldc_pkg::T_IDLE; // R11
				end else if (tif.qtick) begin
					next_st.qcnt = st.qcnt + 7'h1;
					if (st.qcnt + 7'h1 >= {2'h0, tif.ext_q}) begin
						next_st.state = ldc_pkg::T_IDLE; // R19
					end
				end
			end
			ldc_pkg::T_PULSE: begin
				next_st.pcnt = st.pcnt + 32'h1;
				if (st.pcnt == 32'(PULSE_CYC - 1)) begin
					next_st.state = ldc_pkg::T_HOLD; // R13
				end
			end
			ldc_pkg::T_HOLD: begin
				if (!tif.detect) begin
					next_st.state = ldc_pkg::T_IDLE;
				end
			end
			default: begin
				next_st.state = ldc_pkg::T_IDLE;
			end
		endcase
		next_st.out = next_st.state == ldc_pkg::T_ON || next_st.state == ldc_pkg::T_EXT
			|| next_st.state == ldc_pkg::T_PULSE;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign tif.out = st.out;

	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	ext_gated_a: assert property (st.state == ldc_pkg::T_ON // R11
		&& !tif.detect && !tif.allow_ext |=> st.state == ldc_pkg::T_IDLE && !st.out)
		else $error("extension ran while the phase input forbade it");
	delay_skip_a: assert property (st.state == ldc_pkg::T_IDLE && tif.detect // R11
		&& !tif.pulse_mode && !tif.allow_delay |=> st.out)
		else $error("delay ran while the phase input forbade it");
	ext_cover_c: cover property (st.state == ldc_pkg::T_EXT ##1 st.state == ldc_pkg::T_IDLE);
endmodule

/* ldc_top.sv */
// Four-channel loop detector configuration, scanning, timing and serial addressing core
`timescale 1ns/1ns
// Summary of operation
// R1: Configuration comes from manual switches or from software-written stored settings.
// R2: Eight thresholds in 2:1 steps, each an inductance change in nanohenries.
// R3: A channel detects only when the inductance drop exceeds its threshold.
// R4: One shared oscillator scans the channels one at a time.
// R5: One of three oscillator frequencies from a switch or software.
// R6: Each serial port supports multidrop with up to eight units.
// R7: Expansion module: 32 units, independent rear port, front traffic leaves rear alone.
// R8: Software bit rate 1200 to 19200; independent front and rear with module.
// R9: Software address 128 to 254; 255 is accepted only on the front port.
// R10: Four-bit back-panel address selects 16 addresses when software enables it.
// R11: Phase true blocks delay and allows extension; false does the reverse.
// R12: Software can turn phase gating off so both timings always run.
// R13: Each channel gives presence or pulse output, from switches or software.
// R14: Selector off disables the channel output and its detect and fault lamps.
// R15: Selector has off, seven presence and eight pulse threshold positions.
// R16: Each selector step halves the threshold; most sensitive is 8 nH.
// R17: Each channel tunes to its loop within four seconds after power-up.
// R18: The loop reference follows slow drift without false or lost detection.
// R19: Delay 0 to 31 s in 1 s steps; extension 0 to 7.75 s in quarters.
// R20: The least sensitive threshold is a 1024 nH change.
// R21: Back-panel addressing replaces the software address; front wildcard still works.
// R22: Switch inputs are synchronised and debounced before use.
module ldc_top #(
	parameter int QTICK_CYC = ldc_pkg::QTICK_CYC,
	parameter int DEB_CYC = ldc_pkg::DEB_CYC,
	parameter int TUNE_CYC = ldc_pkg::TUNE_CYC,
	parameter int PULSE_CYC = ldc_pkg::PULSE_CYC
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic cfg_from_sw,
	input wire logic [15:0] sel_pin,
	input wire logic [1:0] freq_pin,
	input wire logic phase_pin,
	input wire logic [3:0] bp_addr_pin,
	input wire logic comm_module_pin,
	input wire logic [3:0] sw_mode_pulse,
	input wire logic [11:0] sw_thr_idx,
	input wire logic [3:0] sw_chan_off,
	input wire logic [1:0] sw_freq,
	input wire logic gate_en,
	input wire logic [19:0] delay_sec,
	input wire logic [19:0] ext_qsec,
	input wire logic meas_valid,
	input wire logic [21:0] meas_l,
	input wire logic [3:0] fault_in,
	input wire logic [2:0] baud_front,
	input wire logic [2:0] baud_rear,
	input wire logic [7:0] sw_addr,
	input wire logic bp_addr_en,
	input wire logic rx_front_valid,
	input wire logic [7:0] rx_front_addr,
	input wire logic rx_rear_valid,
	input wire logic [7:0] rx_rear_addr,
	input wire logic front_busy,
	output logic [3:0] det_out,
	output logic [3:0] led_detect,
	output logic [3:0] led_fault,
	output logic [1:0] osc_sel,
	output logic [1:0] osc_freq,
	output logic tune_done,
	output logic tune_fail,
	output logic [7:0] unit_addr,
	output logic [15:0] baud_div_front,
	output logic [15:0] baud_div_rear,
	output logic [5:0] md_limit,
	output logic rear_indep,
	output logic hit_front,
	output logic hit_rear
);
	typedef struct packed {
		logic [3:0] tuned;
		logic [3:0][21:0] base;
		logic [3:0] raw;
		logic [3:0] drift_due;
		logic [1:0] osc_sel;
		logic [1:0] osc_freq;
		logic [31:0] qcnt;
		logic qtick;
		logic [31:0] tcnt;
		logic tune_done;
		logic tune_fail;
		logic [3:0] det_out;
		logic [3:0] led_detect;
		logic [3:0] led_fault;
		logic [7:0] unit_addr;
		logic [15:0] baud_div_front;
		logic [15:0] baud_div_rear;
		logic [5:0] md_limit;
		logic rear_indep;
		logic hit_front;
		logic hit_rear;
	} ldc_top_state_type;
	ldc_top_state_type st;
	ldc_top_state_type next_st;

	logic [ldc_pkg::DB_W-1:0] db;
	logic [3:0] off_v;
	logic [3:0] pulse_v;
	logic [3:0][2:0] idx_v;
	logic [3:0] tout;
	logic [1:0] freq_db;
	logic [3:0] bp_db;
	logic phase_db;
	logic comm_db;
	logic allow_delay;
	logic allow_ext;
	logic [21:0] cur_base;
	logic [21:0] cur_delta;
	logic [10:0] cur_thr;
	logic cur_hit;

	// Every pin-level switch and strap is synchronised and filtered here
	ldc_debounce #(
		.W(ldc_pkg::DB_W),
		.STABLE_CYC(DEB_CYC)
	) u_deb (
		.mclk(mclk),
		.nrst(nrst),
		.din({comm_module_pin, phase_pin, bp_addr_pin, freq_pin, sel_pin}), // R22
		.dout(db)
	);
	assign freq_db = db[ldc_pkg::DB_FREQ +: 2];
	assign bp_db = db[ldc_pkg::DB_BP +: 4];
	assign phase_db = db[ldc_pkg::DB_PHASE];
	assign comm_db = db[ldc_pkg::DB_COMM];

	// Phase gating; with gating off both timings are always permitted
	assign allow_delay = !gate_en || !phase_db; // R11 R12
	assign allow_ext = !gate_en || phase_db; // R11 R12

	// Per-channel source select and output timer
	ldc_tmr_if tif[ldc_pkg::CH_N] ();
	genvar g;
	generate
		for (g = 0; g < ldc_pkg::CH_N; g++) begin : g_ch
			logic [3:0] sel;
			assign sel = db[ldc_pkg::DB_SEL + 4 * g +: 4];
			// Position 0 is off, 1..7 presence, 8..15 pulse; low bits index the threshold
			assign off_v[g] = cfg_from_sw ? sw_chan_off[g] : sel == ldc_pkg::SEL_OFF; // R1 R14
			assign pulse_v[g] = cfg_from_sw ? sw_mode_pulse[g] : sel[3]; // R13 R15
			assign idx_v[g] = cfg_from_sw ? sw_thr_idx[3 * g +: 3] : sel[2:0]; // R15 R16
			assign tif[g].detect = st.raw[g];
			assign tif[g].pulse_mode = pulse_v[g];
			assign tif[g].allow_delay = allow_delay;
			assign tif[g].allow_ext = allow_ext;
			assign tif[g].qtick = st.qtick;
			assign tif[g].delay_q = 7'(delay_sec[5 * g +: 5] * ldc_pkg::QTR_PER_SEC); // R19
			assign tif[g].ext_q = ext_qsec[5 * g +: 5]; // R19
			assign tout[g] = tif[g].out;
			ldc_timer #(
				.PULSE_CYC(PULSE_CYC)
			) u_tmr (
				.mclk(mclk),
				.nrst(nrst),
				.tif(tif[g])
			);
		end
	endgenerate

	// Compare the scanned channel against its reference; a drop means a vehicle
	assign cur_base = st.base[st.osc_sel];
	assign cur_delta = cur_base - meas_l;
	assign cur_thr = ldc_pkg::thr_nh(idx_v[st.osc_sel]); // R2 R16 R20
	assign cur_hit = cur_base > meas_l && cur_delta > 22'(cur_thr); // R3

	// Call decision shared by the output and its lamp; off silences both
	function automatic logic chan_call(input logic off, input logic tmr, input logic flt);
		chan_call = !off && (tmr || flt);
	endfunction

	// All next-state logic in one place
	always_comb begin
		next_st = st;
		// Quarter-second time base shared by timers and drift tracking
		if (st.qcnt == 32'(QTICK_CYC - 1)) begin
			next_st.qcnt = 32'h0;
			next_st.qtick = 1'b1;
		end else begin
			next_st.qcnt = st.qcnt + 32'h1;
			next_st.qtick = 1'b0;
		end
		// One measurement closes the dwell; the oscillator moves on to the next channel
		if (meas_valid) begin
			next_st.osc_sel = st.osc_sel + 2'h1; // R4
			for (int k = 0; k < ldc_pkg::CH_N; k++) begin
				if (2'(k) == st.osc_sel && !off_v[k]) begin
					if (!st.tuned[k]) begin
						next_st.base[k] = meas_l; // R17
						next_st.tuned[k] = 1'b1;
						next_st.raw[k] = 1'b0;
					end else begin
						next_st.raw[k] = cur_hit; // R3
						// Creep one nH per quarter second, frozen while a vehicle sits
						if (!cur_hit && st.drift_due[k]) begin
							next_st.drift_due[k] = 1'b0;
							if (meas_l > cur_base) begin
								next_st.base[k] = cur_base + 22'h1; // R18
							end else if (meas_l < cur_base) begin
								next_st.base[k] = cur_base - 22'h1; // R18
							end
						end
					end
				end
			end
		end
		// A fresh tick wins over the clear above
		next_st.drift_due = next_st.drift_due | {4{st.qtick}};
		// Channels switched off forget their tuning and retune when turned back on
		for (int k = 0; k < ldc_pkg::CH_N; k++) begin
			if (off_v[k]) begin
				next_st.tuned[k] = 1'b0;
				next_st.raw[k] = 1'b0;
			end
		end
		// Power-up tuning window
		if (st.tcnt != 32'(TUNE_CYC)) begin
			next_st.tcnt = st.tcnt + 32'h1;
		end
		next_st.tune_done = &(st.tuned | off_v) && off_v != 4'hf; // R17
		if (st.tcnt == 32'(TUNE_CYC - 1) && !st.tune_done) begin
			next_st.tune_fail = 1'b1; // R17
		end
		// The unused fourth switch code keeps the last frequency
		if ((cfg_from_sw ? sw_freq : freq_db) != ldc_pkg::FREQ_ILLEGAL) begin
			next_st.osc_freq = cfg_from_sw ? sw_freq : freq_db; // R5
		end
		// Outputs and lamps; a fault forces a call, but off silences everything
		for (int k = 0; k < ldc_pkg::CH_N; k++) begin
			next_st.det_out[k] = chan_call(off_v[k], tout[k], fault_in[k]); // R14
			next_st.led_detect[k] = chan_call(off_v[k], tout[k], fault_in[k]); // R14
			next_st.led_fault[k] = !off_v[k] && fault_in[k]; // R14
		end
		// Address: back panel overrides; an out-of-range software value is ignored
		if (bp_addr_en) begin
			next_st.unit_addr = ldc_pkg::ADDR_BP_BASE | {4'h0, bp_db}; // R10 R21
		end else if (sw_addr >= ldc_pkg::ADDR_MIN && sw_addr <= ldc_pkg::ADDR_MAX) begin
			next_st.unit_addr = sw_addr; // R9
		end
		next_st.hit_front = rx_front_valid
			&& (rx_front_addr == st.unit_addr || rx_front_addr == ldc_pkg::ADDR_WILD); // R9 R21
		// Without the module both ports share one line, so front traffic blocks the rear
		next_st.hit_rear = rx_rear_valid && rx_rear_addr == st.unit_addr
			&& (comm_db || !front_busy); // R7 R9
		next_st.baud_div_front = ldc_pkg::baud_div(baud_front); // R8
		next_st.baud_div_rear = ldc_pkg::baud_div(comm_db ? baud_rear : baud_front); // R8
		next_st.md_limit = comm_db ? ldc_pkg::MD_EXP : ldc_pkg::MD_BASIC; // R6 R7
		next_st.rear_indep = comm_db; // R7
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st <= '0;
			st.osc_freq <= ldc_pkg::FREQ_RST;
			st.unit_addr <= ldc_pkg::ADDR_RST;
			st.baud_div_front <= ldc_pkg::BAUD_DIV_RST;
			st.baud_div_rear <= ldc_pkg::BAUD_DIV_RST;
			st.md_limit <= ldc_pkg::MD_BASIC;
		end else begin
			st <= next_st;
		end
	end

	assign det_out = st.det_out;
	assign led_detect = st.led_detect;
	assign led_fault = st.led_fault;
	assign osc_sel = st.osc_sel;
	assign osc_freq = st.osc_freq;
	assign tune_done = st.tune_done;
	assign tune_fail = st.tune_fail;
	assign unit_addr = st.unit_addr;
	assign baud_div_front = st.baud_div_front;
	assign baud_div_rear = st.baud_div_rear;
	assign md_limit = st.md_limit;
	assign rear_indep = st.rear_indep;
	assign hit_front = st.hit_front;
	assign hit_rear = st.hit_rear;

	// Checks on the observable behaviour
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	chan_off_quiet_a: assert property (1'b1 |=> ((det_out | led_detect | led_fault) // R14
		& $past(off_v)) == 4'h0)
		else $error("disabled channel drove its output or lamps");
	scan_step_a: assert property (meas_valid |=> osc_sel == $past(osc_sel) + 2'h1) // R4
		else $error("oscillator did not advance to the next channel");
	scan_hold_a: assert property (!meas_valid // R4
		|=> $stable(osc_sel))
		else $error("oscillator moved without a reading");
	below_thr_a: assert property (meas_valid && st.tuned[st.osc_sel] // R3
		&& !off_v[st.osc_sel] && !cur_hit |=> !st.raw[$past(st.osc_sel)])
		else $error("detection without exceeding the threshold");
	freq_legal_a: assert property (osc_freq != ldc_pkg::FREQ_ILLEGAL) // R5
		else $error("oscillator frequency code out of range");
	addr_range_a: assert property (unit_addr >= ldc_pkg::ADDR_MIN // R9
		&& unit_addr <= ldc_pkg::ADDR_MAX)
		else $error("unit address left the legal range");
	wild_front_a: assert property (rx_front_valid && rx_front_addr == ldc_pkg::ADDR_WILD // R9
		|=> hit_front)
		else $error("wildcard refused on the front port");
	wild_rear_a: assert property (rx_rear_valid && rx_rear_addr == ldc_pkg::ADDR_WILD // R9
		|=> !hit_rear)
		else $error("wildcard accepted on the rear port");
	hit_pulse_a: assert property (!rx_front_valid // R9
		|=> !hit_front)
		else $error("front match without a frame");
	bp_addr_a: assert property (bp_addr_en |=> unit_addr == (ldc_pkg::ADDR_BP_BASE // R10
		| {4'h0, $past(bp_db)}))
		else $error("back-panel address not applied");
	rear_indep_a: assert property (comm_db && rx_rear_valid // R7
		&& rx_rear_addr == st.unit_addr |=> hit_rear)
		else $error("rear port disturbed with expansion module fitted");
	rear_block_a: assert property (!comm_db && front_busy // R7
		|=> !hit_rear)
		else $error("rear port answered on a busy shared line");
	rear_baud_a: assert property (!comm_db |=> baud_div_rear == baud_div_front) // R8
		else $error("rear rate differs from front without expansion module");
	drop_limit_a: assert property (md_limit == (rear_indep ? ldc_pkg::MD_EXP // R6
		: ldc_pkg::MD_BASIC))
		else $error("multidrop limit does not match the module state");
	// Tuning window and reference tracking
	fail_sticky_a: assert property (tune_fail |=> tune_fail) // R17
		else $error("tuning failure flag cleared");
	fail_when_a: assert property ($rose(tune_fail) // R17
		|-> $past(st.tcnt) == 32'(TUNE_CYC - 1) && !$past(tune_done))
		else $error("tuning failure flagged inside the window");
	tune_quiet_a: assert property (meas_valid && !st.tuned[st.osc_sel] // R17
		|=> !st.raw[$past(st.osc_sel)])
		else $error("first reading after tuning raised a detect");
	off_retune_a: assert property (1'b1 // R17
		|=> (st.tuned & $past(off_v)) == 4'h0)
		else $error("disabled channel kept its tuning");
	ref_freeze_a: assert property (meas_valid && st.tuned[st.osc_sel] && cur_hit // R18
		|=> st.base[$past(st.osc_sel)] == $past(cur_base))
		else $error("reference moved under a vehicle");
	det_cover_c: cover property ($rose(det_out[0]));
	hit_cover_c: cover property (hit_front && unit_addr != ldc_pkg::ADDR_RST);
	tune_cover_c: cover property ($rose(tune_done));
	gate_cover_c: cover property (gate_en && phase_db && $rose(det_out[0]));
endmodule

/* ldc_loop_model.sv */
// Loop front end model that answers the scanned channel with a reading
`timescale 1ns/1ns
module ldc_loop_model #(
	parameter logic [21:0] BASE = 22'h0186a0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [1:0] osc_sel,
	input wire logic [43:0] drop,
	output logic meas_valid,
	output logic [21:0] meas_l
);
	logic [1:0] cnt;
	// One reading every fourth cycle, for the channel the oscillator serves
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 2'h0;
			meas_valid <= 1'b0;
			meas_l <= 22'h0;
		end else begin
			cnt <= cnt + 2'h1;
			meas_valid <= (cnt == 2'h3);
			// Between readings the bus shows junk, so a stale value is never trusted
			meas_l <= (cnt == 2'h3) ? BASE - 22'(drop[osc_sel*11 +: 11]) : ~meas_l;
		end
	end
endmodule

/* testbench.sv */
// Self-checking bench for the loop detector configuration core
`timescale 1ns/1ns
module testbench;
	logic mclk = 0, nrst = 0, cfg_from_sw = 1, phase_pin = 0, comm_module_pin = 0;
	logic gate_en = 0, bp_addr_en = 0, rx_front_valid = 0, rx_rear_valid = 0, front_busy = 0;
	logic [15:0] sel_pin = 16'h0;
	logic [1:0] freq_pin = 2'h0, sw_freq = 2'h0;
	logic [3:0] bp_addr_pin = 4'h0, sw_mode_pulse = 4'h0, sw_chan_off = 4'h8, fault_in = 4'h0;
	logic [11:0] sw_thr_idx = 12'h0c7;
	logic [19:0] delay_sec = 20'h0, ext_qsec = 20'h0;
	logic [2:0] baud_front = 3'h3, baud_rear = 3'h3;
	logic [7:0] sw_addr = 8'h80, rx_front_addr = 8'h0, rx_rear_addr = 8'h0;
	logic [43:0] drop = 44'h0;
	logic meas_valid, tune_done, tune_fail, rear_indep, hit_front, hit_rear;
	logic [21:0] meas_l;
	logic [3:0] det_out, led_detect, led_fault;
	logic [1:0] osc_sel, osc_freq;
	logic [7:0] unit_addr;
	logic [15:0] baud_div_front, baud_div_rear;
	logic [5:0] md_limit;
	int n_mismatch = 0, num_checks = 0;
	int rates [6] = '{1200, 2400, 4800, 9600, 19200, 9600};
	logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

	// Short counts keep the run brief; expectations below use the same figures
	ldc_top #(.QTICK_CYC(20), .DEB_CYC(4), .TUNE_CYC(2000), .PULSE_CYC(10)) DUT (
		.mclk, .nrst, .cfg_from_sw, .sel_pin, .freq_pin, .phase_pin, .bp_addr_pin,
		.comm_module_pin, .sw_mode_pulse, .sw_thr_idx, .sw_chan_off, .sw_freq, .gate_en,
		.delay_sec, .ext_qsec, .meas_valid, .meas_l, .fault_in, .baud_front, .baud_rear,
		.sw_addr, .bp_addr_en, .rx_front_valid, .rx_front_addr, .rx_rear_valid,
		.rx_rear_addr, .front_busy, .det_out, .led_detect, .led_fault, .osc_sel, .osc_freq,
		.tune_done, .tune_fail, .unit_addr, .baud_div_front, .baud_div_rear, .md_limit,
		.rear_indep, .hit_front, .hit_rear);
	ldc_loop_model loop (.mclk, .nrst, .osc_sel, .drop, .meas_valid, .meas_l);

	// 250 MHz clock
	always #2 mclk = ~mclk;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Inputs always move 1 ns after the rising edge
	task automatic step(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	// One frame address; the pulse may land in either of two cycles, but only once
	task automatic send(logic rear, logic [7:0] a, logic exp);
		logic [1:0] h;
		rx_front_valid = !rear;
		rx_rear_valid = rear;
		rx_front_addr = a;
		rx_rear_addr = a;
		step(1);
		h[0] = rear ? hit_rear : hit_front;
		rx_front_valid = 0;
		rx_rear_valid = 0;
		step(1);
		h[1] = rear ? hit_rear : hit_front;
		check("hit", {h[0] & h[1], h[0] | h[1]}, {1'b0, exp});
	endtask

	task automatic s_reset();
		check("unit_addr", unit_addr, 16'h0080);
		check("baud_front", baud_div_front, 16'd1627);
		check("md_limit", md_limit, 16'h0008);
		check("det_out", det_out, 16'h0000);
	endtask

	task automatic s_baud();
		baud_rear = 3'h2;
		for (int i = 0; i < 6; i++) begin
			baud_front = codes[i];
			step(2);
			check("baud_front", baud_div_front, 16'(250000000 / (16 * rates[i])));
			check("baud_rear", baud_div_rear, 16'(250000000 / (16 * rates[i])));
		end
		comm_module_pin = 1;
		baud_front = 3'h0;
		baud_rear = 3'h4;
		step(20);
		check("md_limit", md_limit, 16'h0020);
		check("rear_indep", rear_indep, 16'h0001);
		check("baud_front", baud_div_front, 16'd13020);
		check("baud_rear", baud_div_rear, 16'd813);
	endtask

	task automatic s_addr();
		sw_addr = 8'ha5;
		step(2);
		check("unit_addr", unit_addr, 16'h00a5);
		send(0, 8'ha5, 1);
		send(0, 8'hff, 1);
		send(1, 8'hff, 0);
		front_busy = 1;
		send(1, 8'ha5, 1);
		sw_addr = 8'h7f;
		step(2);
		check("unit_addr", unit_addr, 16'h00a5);
		bp_addr_pin = 4'h5;
		bp_addr_en = 1;
		step(20);
		check("unit_addr", unit_addr, 16'h0085);
		send(0, 8'h85, 1);
		send(0, 8'hff, 1);
		send(0, 8'ha5, 0);
		bp_addr_en = 0;
		comm_module_pin = 0;
		step(20);
		send(1, 8'h85, 0);
		front_busy = 0;
		send(1, 8'h85, 1);
	endtask

	task automatic s_freq();
		sw_freq = 2'h2;
		step(2);
		check("osc_freq", osc_freq, 16'h0002);
		sw_freq = 2'h3;
		step(2);
		check("osc_freq", osc_freq, 16'h0002);
		cfg_from_sw = 0;
		freq_pin = 2'h1;
		step(20);
		check("osc_freq", osc_freq, 16'h0001);
		cfg_from_sw = 1;
	endtask

	// Thresholds 8, 1024, 128 nH on channels 0..2; channel 3 switched off
	task automatic s_detect();
		int i;
		step(400);
		check("tune_done", tune_done, 16'h0001);
		check("tune_fail", tune_fail, 16'h0000);
		drop = {11'd2000, 11'd129, 11'd1024, 11'd9};
		step(100);
		check("det_out", det_out, 16'h0005);
		check("led_detect", led_detect, 16'h0005);
		fault_in = 4'h8;
		step(4);
		check("led_fault", led_fault, 16'h0000);
		fault_in = 4'h0;
		drop = 44'h0;
		step(400);
		sw_mode_pulse = 4'h2;
		drop = {11'd0, 11'd129, 11'd1025, 11'd8};
		for (i = 0; i < 200 && det_out[1] !== 1'b1; i++) step(1);
		check("pulse_seen", 16'(i < 200), 16'h0001);
		step(20);
		check("det_out", det_out, 16'h0004);
	endtask

	// Channel 0, 1 s delay and 4 quarter extension: gating off, phase true, phase false
	task automatic s_timing();
		drop = 44'h0;
		sw_mode_pulse = 4'h0;
		delay_sec = 20'h1;
		ext_qsec = 20'h4;
		for (int m = 0; m < 3; m++) begin
			gate_en = m != 0;
			phase_pin = m == 1;
			step(40);
			drop = 44'h64;
			step(50);
			check("delay_run", det_out, {15'h0, m == 1});
			step(60);
			check("delay_end", det_out, 16'h0001);
			drop = 44'h0;
			step(25);
			check("ext_run", det_out, {15'h0, m != 2});
			step(85);
			check("ext_end", det_out, 16'h0000);
		end
	endtask

	// Main sequence: two cycles of reset, then each scenario in turn
	initial begin
		step(2);
		nrst = 1;
		step(1);
		s_reset();
		s_baud();
		s_addr();
		s_freq();
		s_detect();
		s_timing();
		give_verdict();
	end
endmodule
